// ---- rtic_io.v ----
// Purpose: Remote-control and process-channel TTL front end
// Assumes: All pins arrive asynchronously through opto-isolators
// Notes: Channel activity is set by software or by linked inputs
//
// Register access over APB and the register offsets were decided locally.
`include "rtic_map.vh"
`default_nettype none

module rtic_io (
    input wire CLK_SYS, // System clock, 250 MHz
    input wire RST, // Asynchronous reset, active high
    input wire PSEL, // APB select
    input wire PENABLE, // APB access phase
    input wire PWRITE, // APB write when high
    input wire [11:0] PADDR, // APB byte address
    input wire [31:0] PWDATA, // APB write data
    output reg [31:0] PRDATA, // APB read data
    output reg PREADY, // APB ready
    output reg PSLVERR, // APB error on unmapped address
    input wire [7:0] PROC_IN, // Process channel input pins
    input wire ION_GAUGE_A_REMOTE_ON, // Ion gauge A command pin
    input wire ION_GAUGE_B_REMOTE_ON, // Ion gauge B command pin
    input wire DEGAS_REMOTE, // Degas command pin
    input wire EMISSION_LOCKOUT_N, // Low forces emission off
    input wire GAUGE_KEYPAD_LOCKOUT_N, // Low locks gauge keypad
    input wire THERMAL_GAUGE_A_REMOTE_OFF, // Thermal gauge A pin
    input wire THERMAL_GAUGE_B_REMOTE_OFF, // Thermal gauge B pin
    input wire LOG_CLEAR_N, // Fall clears the data log
    input wire REMOTE_GAUGE_OVERRIDE, // High ignores five gauge pins
    input wire FILAMENT_A_SELECT, // Filament A select pin
    input wire FILAMENT_B_SELECT, // Filament B select pin
    input wire PANEL_LOCKOUT_N, // Low locks the whole panel
    output reg [7:0] PROC_OUT_N, // Channel outputs, low active
    output reg ION_A_EMIT, // Ion gauge A emission enable
    output reg ION_B_EMIT, // Ion gauge B emission enable
    output reg DEGAS_RUN, // Degas running request
    output reg THERMAL_A_ON, // Thermal gauge A powered
    output reg THERMAL_B_ON, // Thermal gauge B powered
    output reg FILAMENT_A_ON, // Filament A selected
    output reg FILAMENT_B_ON, // Filament B selected
    output reg LOG_CLEAR, // One-cycle log erase pulse
    output reg GAUGE_KEYPAD_EN, // Gauge keypad accepted
    output reg TOUCH_EN // Touchscreen accepted
);

    localparam NI = `RTIC_NUM_IN;
    // Compared at full width so the count is never cut
    localparam [31:0] FILT_LAST = `RTIC_FILT_CYC - 1;

    wire [NI-1:0] pins; // All asynchronous inputs
    reg [NI-1:0] s1_ff; // First synchroniser stage
    reg [NI-1:0] s2_ff; // Second synchroniser stage
    reg [NI-1:0] s3_ff; // Third synchroniser stage
    reg [NI-1:0] filt_ff; // Filtered input levels
    reg [NI-1:0] fall_ff; // One-cycle falling edge pulses
    reg [NI-1:0] rise_ff; // One-cycle rising edge pulses
    reg [7:0] manual_ff; // Software channel activity
    reg [7:0] link_ff; // Channel follows its input pin
    reg [7:0] pol_ff; // Level that activates a channel
    reg [11:0] event_ff; // Sticky remote edge events
    reg [6:0] gauge_ff; // Requested gauge state
    reg [6:0] nxt_gauge; // Next gauge state
    reg [7:0] chan_act; // Resolved channel activity
    reg [31:0] nxt_rdata; // Read mux result
    reg nxt_err; // Unmapped address flag
    wire setup; // APB setup phase
    wire wr_go; // Write commits this edge
    wire [11:0] any_edge; // Any remote edge this cycle

    // Pins in header order; process inputs at the bottom
    // Remote pins sit at bits 8 to 19, as the position macros say
    assign pins = {PANEL_LOCKOUT_N, FILAMENT_B_SELECT,
        FILAMENT_A_SELECT, REMOTE_GAUGE_OVERRIDE, LOG_CLEAR_N,
        THERMAL_GAUGE_B_REMOTE_OFF, THERMAL_GAUGE_A_REMOTE_OFF,
        GAUGE_KEYPAD_LOCKOUT_N, EMISSION_LOCKOUT_N, DEGAS_REMOTE,
        ION_GAUGE_B_REMOTE_ON, ION_GAUGE_A_REMOTE_ON, PROC_IN};

    // Synchroniser: three flops, the first read only by the second
    // Three stages cost three cycles but give metastability margin
    always @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            s1_ff <= {NI{`RTIC_IN_IDLE}};
            s2_ff <= {NI{`RTIC_IN_IDLE}};
            s3_ff <= {NI{`RTIC_IN_IDLE}};
        end
        else
        begin
            s1_ff <= pins;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Per-input glitch filter and edge detector
    genvar gi;
    generate
        for (gi = 0; gi < NI; gi = gi + 1)
        begin : g_filt
            reg [7:0] cnt_ff; // Stable time counter
            // Level is accepted only after a full quiet interval,
            // so opto bounce cannot emit a second pulse
            always @(posedge CLK_SYS or posedge RST)
            begin
                if (RST)
                begin
                    cnt_ff <= 8'h00;
                    filt_ff[gi] <= `RTIC_IN_IDLE;
                    fall_ff[gi] <= 1'b0;
                    rise_ff[gi] <= 1'b0;
                end
                else if (s2_ff[gi] != s3_ff[gi] ||
                    s3_ff[gi] == filt_ff[gi])
                begin
                    // Disagreement or no change: restart the wait
                    cnt_ff <= 8'h00;
                    fall_ff[gi] <= 1'b0;
                    rise_ff[gi] <= 1'b0;
                end
                else if ({24'h000000, cnt_ff} == FILT_LAST)
                begin
                    // Accept: exactly one pulse per edge
                    cnt_ff <= 8'h00;
                    filt_ff[gi] <= s3_ff[gi];
                    fall_ff[gi] <= ~s3_ff[gi];
                    rise_ff[gi] <= s3_ff[gi];
                end
                else
                begin
                    cnt_ff <= cnt_ff + 8'h01;
                    fall_ff[gi] <= 1'b0;
                    rise_ff[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Gauge command state from remote edges
    always @*
    begin
        nxt_gauge = gauge_ff;
        // Override discards these edges; nothing is queued
        if (!filt_ff[`RTIC_IN_OVERRIDE])
        begin
            if (fall_ff[`RTIC_IN_ION_A])
                nxt_gauge[`RTIC_GS_ION_A] = 1'b1;
            else if (rise_ff[`RTIC_IN_ION_A])
                nxt_gauge[`RTIC_GS_ION_A] = 1'b0;
            if (fall_ff[`RTIC_IN_ION_B])
                nxt_gauge[`RTIC_GS_ION_B] = 1'b1;
            else if (rise_ff[`RTIC_IN_ION_B])
                nxt_gauge[`RTIC_GS_ION_B] = 1'b0;
            if (fall_ff[`RTIC_IN_DEGAS])
                nxt_gauge[`RTIC_GS_DEGAS] = 1'b1;
            else if (rise_ff[`RTIC_IN_DEGAS])
                nxt_gauge[`RTIC_GS_DEGAS] = 1'b0;
            if (fall_ff[`RTIC_IN_FIL_A])
                nxt_gauge[`RTIC_GS_FIL_A] = 1'b1;
            else if (rise_ff[`RTIC_IN_FIL_A])
                nxt_gauge[`RTIC_GS_FIL_A] = 1'b0;
            if (fall_ff[`RTIC_IN_FIL_B])
                nxt_gauge[`RTIC_GS_FIL_B] = 1'b1;
            else if (rise_ff[`RTIC_IN_FIL_B])
                nxt_gauge[`RTIC_GS_FIL_B] = 1'b0;
        end
        // Thermal gauges are never overridden
        // A fall and a rise never arrive in the same cycle
        if (fall_ff[`RTIC_IN_THERM_A])
            nxt_gauge[`RTIC_GS_THERM_A] = 1'b0;
        else if (rise_ff[`RTIC_IN_THERM_A])
            nxt_gauge[`RTIC_GS_THERM_A] = 1'b1;
        if (fall_ff[`RTIC_IN_THERM_B])
            nxt_gauge[`RTIC_GS_THERM_B] = 1'b0;
        else if (rise_ff[`RTIC_IN_THERM_B])
            nxt_gauge[`RTIC_GS_THERM_B] = 1'b1;
    end

    // Channel activity: linked channels follow their pin
    // Unlinked channels take their level from software
    always @*
    begin
        chan_act = (link_ff & ~(filt_ff[7:0] ^ pol_ff)) |
            (~link_ff & manual_ff);
    end

    // Setup latches the answer; a write commits at the ready edge
    assign setup = PSEL & ~PENABLE;
    assign wr_go = PSEL & PENABLE & PWRITE & PREADY;
    // Any remote edge this cycle sets its sticky event flag
    assign any_edge = fall_ff[NI-1:8] | rise_ff[NI-1:8];

    // Read mux and address decode for the setup phase
    // Decoded early so the answer stands one cycle later
    always @*
    begin
        nxt_rdata = 32'h00000000;
        nxt_err = 1'b0;
        if (PADDR == `RTIC_REG_MANUAL)
            nxt_rdata[7:0] = manual_ff;
        else if (PADDR == `RTIC_REG_LINK)
            nxt_rdata[7:0] = link_ff;
        else if (PADDR == `RTIC_REG_POLARITY)
            nxt_rdata[7:0] = pol_ff;
        else if (PADDR == `RTIC_REG_CHAN_STAT)
            nxt_rdata[15:0] = {filt_ff[7:0], chan_act};
        else if (PADDR == `RTIC_REG_REMOTE_LVL)
            nxt_rdata[11:0] = filt_ff[NI-1:8];
        else if (PADDR == `RTIC_REG_GAUGE)
            nxt_rdata[6:0] = gauge_ff;
        else if (PADDR == `RTIC_REG_EVENT)
            nxt_rdata[11:0] = event_ff;
        else
            nxt_err = 1'b1; // Unmapped: error, reads zero
    end

    // APB slave: one cycle of access, answer registered
    // Read data is kept until the next read setup
    always @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            PRDATA <= 32'h00000000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY <= setup;
            PSLVERR <= setup & nxt_err;
            if (setup && !PWRITE)
                PRDATA <= nxt_rdata;
        end
    end

    // Software registers; edge events win over a clear
    // Writes to read-only or unmapped offsets are dropped
    always @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            manual_ff <= 8'h00;
            link_ff <= 8'h00;
            pol_ff <= 8'h00;
            event_ff <= 12'h000;
        end
        else
        begin
            if (wr_go && PADDR == `RTIC_REG_MANUAL)
                manual_ff <= PWDATA[7:0];
            if (wr_go && PADDR == `RTIC_REG_LINK)
                link_ff <= PWDATA[7:0];
            if (wr_go && PADDR == `RTIC_REG_POLARITY)
                pol_ff <= PWDATA[7:0];
            if (wr_go && PADDR == `RTIC_REG_EVENT)
                event_ff <= (event_ff & ~PWDATA[11:0]) | any_edge;
            else
                event_ff <= event_ff | any_edge;
        end
    end

    // Gauge state and all pin-facing outputs
    always @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            gauge_ff <= `RTIC_RST_GAUGE;
            PROC_OUT_N <= ~`RTIC_RST_CHAN;
            ION_A_EMIT <= 1'b0;
            ION_B_EMIT <= 1'b0;
            DEGAS_RUN <= 1'b0;
            THERMAL_A_ON <= 1'b1;
            THERMAL_B_ON <= 1'b1;
            FILAMENT_A_ON <= 1'b0;
            FILAMENT_B_ON <= 1'b0;
            LOG_CLEAR <= 1'b0;
            GAUGE_KEYPAD_EN <= 1'b0;
            TOUCH_EN <= 1'b0;
        end
        else
        begin
            gauge_ff <= nxt_gauge;
            PROC_OUT_N <= ~chan_act;
            // Lockout gates the output only; the stored request
            // survives, so emission returns once lockout lifts
            ION_A_EMIT <= nxt_gauge[`RTIC_GS_ION_A] &
                filt_ff[`RTIC_IN_LOCKOUT];
            ION_B_EMIT <= nxt_gauge[`RTIC_GS_ION_B] &
                filt_ff[`RTIC_IN_LOCKOUT];
            DEGAS_RUN <= nxt_gauge[`RTIC_GS_DEGAS];
            THERMAL_A_ON <= nxt_gauge[`RTIC_GS_THERM_A];
            THERMAL_B_ON <= nxt_gauge[`RTIC_GS_THERM_B];
            FILAMENT_A_ON <= nxt_gauge[`RTIC_GS_FIL_A];
            FILAMENT_B_ON <= nxt_gauge[`RTIC_GS_FIL_B];
            // Only the fall clears the log; the rise is ignored
            LOG_CLEAR <= fall_ff[`RTIC_IN_LOGCLR];
            // Keypad needs both lockouts released
            GAUGE_KEYPAD_EN <= filt_ff[`RTIC_IN_KEYPAD] &
                filt_ff[`RTIC_IN_PANEL];
            TOUCH_EN <= filt_ff[`RTIC_IN_PANEL];
        end
    end

endmodule

`default_nettype wire

// ---- rtic_map.vh ----
// Purpose: Constants for the remote TTL I/O control block
// Assumes: 250 MHz system clock, APB register access
// Notes: Offsets are byte addresses, one 32-bit word each
//
// What this block does
// - Ion gauge input fall on, rise off
// - Degas input fall starts, rise stops
// - Emission lockout low forces emission off
// - Keypad lockout low ignores gauge keypad
// - Thermal gauge input fall off, rise on
// - Log clear on fall only
// - Override high ignores five gauge inputs
// - Filament input fall selects, rise deselects
// - Panel lockout low ignores touchscreen, keypad
// - Channel output pin low while active
// - Linked channel activates on chosen polarity
// - Eight outputs, eight inputs, twelve remotes
`ifndef RTIC_MAP_VH
`define RTIC_MAP_VH

// Register byte offsets
`define RTIC_REG_MANUAL 12'h000
`define RTIC_REG_LINK 12'h004
`define RTIC_REG_POLARITY 12'h008
`define RTIC_REG_CHAN_STAT 12'h00C
`define RTIC_REG_REMOTE_LVL 12'h010
`define RTIC_REG_GAUGE 12'h014
`define RTIC_REG_EVENT 12'h018

// Positions in the combined filtered input vector
`define RTIC_IN_ION_A 8
`define RTIC_IN_ION_B 9
`define RTIC_IN_DEGAS 10
`define RTIC_IN_LOCKOUT 11
`define RTIC_IN_KEYPAD 12
`define RTIC_IN_THERM_A 13
`define RTIC_IN_THERM_B 14
`define RTIC_IN_LOGCLR 15
`define RTIC_IN_OVERRIDE 16
`define RTIC_IN_FIL_A 17
`define RTIC_IN_FIL_B 18
`define RTIC_IN_PANEL 19
`define RTIC_NUM_IN 20

// Gauge state field positions
`define RTIC_GS_ION_A 0
`define RTIC_GS_ION_B 1
`define RTIC_GS_DEGAS 2
`define RTIC_GS_THERM_A 3
`define RTIC_GS_THERM_B 4
`define RTIC_GS_FIL_A 5
`define RTIC_GS_FIL_B 6

// Reset values
`define RTIC_RST_GAUGE 7'h18
`define RTIC_RST_CHAN 8'h00
`define RTIC_IN_IDLE 1'b1

// Glitch filter: input must stand stable this long
`define RTIC_CLK_MHZ 250
`define RTIC_FILT_NS 1000
`define RTIC_FILT_CYC ((`RTIC_FILT_NS * `RTIC_CLK_MHZ + 999) / 1000)

`endif

// ---- rtic_io_sva.sv ----
// Purpose: Port-level checks for the remote TTL front end
// Assumes: Pins pass a 250-cycle filter plus a few sync flops
// Notes: Hold counters saturate so long levels never wrap
`default_nettype none
module rtic_chk (
    input wire logic CLK_SYS, // System clock
    input wire logic RST, // Reset, active high
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB access phase
    input wire logic PREADY, // APB ready
    input wire logic PSLVERR, // APB error
    input wire logic ION_GAUGE_A_REMOTE_ON, // Ion gauge A pin
    input wire logic DEGAS_REMOTE, // Degas pin
    input wire logic EMISSION_LOCKOUT_N, // Emission lockout pin
    input wire logic GAUGE_KEYPAD_LOCKOUT_N, // Keypad lockout pin
    input wire logic LOG_CLEAR_N, // Log clear pin
    input wire logic REMOTE_GAUGE_OVERRIDE, // Override pin
    input wire logic PANEL_LOCKOUT_N, // Panel lockout pin
    input wire logic ION_A_EMIT, // Emission A
    input wire logic ION_B_EMIT, // Emission B
    input wire logic DEGAS_RUN, // Degas running
    input wire logic FILAMENT_A_ON, // Filament A
    input wire logic LOG_CLEAR, // Log erase pulse
    input wire logic GAUGE_KEYPAD_EN, // Keypad accepted
    input wire logic TOUCH_EN // Touchscreen accepted
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] hold; // Levels being held
    logic [8:0] cnt [4]; // Cycles each level has been held
    assign hold = {REMOTE_GAUGE_OVERRIDE, !PANEL_LOCKOUT_N,
        !GAUGE_KEYPAD_LOCKOUT_N, !EMISSION_LOCKOUT_N};
    // Count held cycles; 260 covers filter plus sync latency
    always_ff @(posedge CLK_SYS or posedge RST)
        for (int i = 0; i < 4; i++)
            if (RST || !hold[i])
                cnt[i] <= '0;
            else if (!(&cnt[i]))
                cnt[i] <= cnt[i] + 1'b1;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    apb_answer_a:
        assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
        else $error("APB answer not one cycle after setup");
    apb_err_a:
        assert property (PSLVERR |-> PREADY)
        else $error("Error flag outside access cycle");
    emis_lock_a:
        assert property (cnt[0] >= 260 |-> !ION_A_EMIT && !ION_B_EMIT)
        else $error("Emission on during lockout");
    keypad_lock_a:
        assert property (cnt[1] >= 260 |-> !GAUGE_KEYPAD_EN)
        else $error("Keypad accepted during lockout");
    panel_lock_a:
        assert property (cnt[2] >= 260 |-> !TOUCH_EN && !GAUGE_KEYPAD_EN)
        else $error("Panel accepted during lockout");
    override_hold_a:
        assert property (cnt[3] >= 300 |-> $stable(DEGAS_RUN)
            && $stable(FILAMENT_A_ON))
        else $error("Gauge state moved under override");
    log_single_a:
        assert property (LOG_CLEAR |=> !LOG_CLEAR)
        else $error("Log clear pulse longer than one cycle");
    log_cause_a:
        assert property (LOG_CLEAR |-> !$past(LOG_CLEAR_N, 100))
        else $error("Log clear without a held fall");
    ion_cause_a:
        assert property ($rose(ION_A_EMIT)
            |-> !$past(ION_GAUGE_A_REMOTE_ON, 100))
        else $error("Emission A on without a held fall");
    degas_cause_a:
        assert property ($rose(DEGAS_RUN) |-> !$past(DEGAS_REMOTE, 100))
        else $error("Degas on without a held fall");
    cover property ($rose(ION_A_EMIT));
    cover property (LOG_CLEAR);
    cover property (PSLVERR);
endmodule
bind rtic_io rtic_chk chk (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .ION_GAUGE_A_REMOTE_ON(ION_GAUGE_A_REMOTE_ON),
    .DEGAS_REMOTE(DEGAS_REMOTE), .EMISSION_LOCKOUT_N(EMISSION_LOCKOUT_N),
    .GAUGE_KEYPAD_LOCKOUT_N(GAUGE_KEYPAD_LOCKOUT_N),
    .LOG_CLEAR_N(LOG_CLEAR_N), .REMOTE_GAUGE_OVERRIDE(REMOTE_GAUGE_OVERRIDE),
    .PANEL_LOCKOUT_N(PANEL_LOCKOUT_N), .ION_A_EMIT(ION_A_EMIT),
    .ION_B_EMIT(ION_B_EMIT), .DEGAS_RUN(DEGAS_RUN),
    .FILAMENT_A_ON(FILAMENT_A_ON), .LOG_CLEAR(LOG_CLEAR),
    .GAUGE_KEYPAD_EN(GAUGE_KEYPAD_EN), .TOUCH_EN(TOUCH_EN));
`default_nettype wire

// ---- rtic_ext.sv ----
// Purpose: Far-side equipment driving and sensing the TTL pins
// Assumes: Pins idle high; level changes come from the bench
// Notes: Clean levels only, so filter timing stays predictable
`default_nettype none
module rtic_ext (
    input wire logic [11:0] rem_req, // Wanted remote levels
    input wire logic [7:0] pin_req, // Wanted channel input levels
    input wire logic [7:0] out_n, // Channel output pins
    output logic [11:0] rem_pin, // Remote control pins
    output logic [7:0] proc_pin, // Channel input pins
    output logic [7:0] active // Channels seen active
);
    timeunit 1ns;
    timeprecision 1ps;
    // Remote pins, all twelve presented as held levels
    assign rem_pin = rem_req;
    // Channel inputs; polarity is chosen on the device side
    assign proc_pin = pin_req;
    // Low output pin means the channel is active
    assign active = ~out_n;
endmodule
`default_nettype wire

// ---- rtic_io_tb.sv ----
// Purpose: Self-checking bench for the remote TTL front end
// Assumes: Pins idle high, filter needs 250 stable cycles
// Notes: Each pin step waits 300 cycles for the filter
`default_nettype none
module rtic_io_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h000, rem = 12'hFFF, rp;
    logic [31:0] pwd = 32'h0, prd, rdat;
    logic [7:0] pin = 8'hFF, pp, outn, act;
    wire logic [7:0] g; // Gauge outputs and log clear, one port per bit
    logic prdy, perr, rerr, kpen, tchen;
    int n_mismatch = 0, n_tests = 0, npulse = 0;
    // 250 MHz system clock
    always #2 clk = ~clk;
    // Count log erase pulses
    always @(posedge clk)
        if (g[0] === 1'b1)
            npulse++;
    rtic_ext ext (.rem_req(rem), .pin_req(pin), .out_n(outn),
        .rem_pin(rp), .proc_pin(pp), .active(act));
    rtic_io dut (.CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd), .PRDATA(prd),
        .PREADY(prdy), .PSLVERR(perr), .PROC_IN(pp),
        .ION_GAUGE_A_REMOTE_ON(rp[0]), .ION_GAUGE_B_REMOTE_ON(rp[1]),
        .DEGAS_REMOTE(rp[2]), .EMISSION_LOCKOUT_N(rp[3]),
        .GAUGE_KEYPAD_LOCKOUT_N(rp[4]), .THERMAL_GAUGE_A_REMOTE_OFF(rp[5]),
        .THERMAL_GAUGE_B_REMOTE_OFF(rp[6]), .LOG_CLEAR_N(rp[7]),
        .REMOTE_GAUGE_OVERRIDE(rp[8]), .FILAMENT_A_SELECT(rp[9]),
        .FILAMENT_B_SELECT(rp[10]), .PANEL_LOCKOUT_N(rp[11]),
        .PROC_OUT_N(outn), .ION_A_EMIT(g[7]), .ION_B_EMIT(g[6]),
        .DEGAS_RUN(g[5]), .THERMAL_A_ON(g[4]), .THERMAL_B_ON(g[3]),
        .FILAMENT_A_ON(g[2]), .FILAMENT_B_ON(g[1]), .LOG_CLEAR(g[0]),
        .GAUGE_KEYPAD_EN(kpen), .TOUCH_EN(tchen));
    // Compare one result; unknowns never match
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until ready is seen at an edge
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        // Wait for ready; only the watchdog ends a dead slave
        while (prdy !== 1'b1)
            @(posedge clk);
        rdat = prd;
        rerr = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        // Let an edge pass so the next call never re-drives psel
        @(posedge clk);
    endtask
    // Read and compare data, expecting no error
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk({rerr, rdat}, {1'b0, e});
    endtask
    // Move the remote pins, then let the filter settle
    task automatic step(input logic [11:0] v);
        rem <= v;
        repeat (300) @(posedge clk);
    endtask
    // Print counts and the verdict, then stop
    task automatic test_done;
        $display("compares %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog: the tests need about 4000 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
    initial
    begin
        repeat (6) @(posedge clk);
        chk(g, 8'h18);
        chk(outn, 8'hFF);
        rst <= 1'b0;
        @(posedge clk);
        $display("test reset done");
        rd(12'h014, 32'h18);
        xfer(1'b0, 12'h01C, 32'h0);
        chk({rerr, rdat}, 33'h100000000);
        xfer(1'b1, 12'h000, 32'hA5);
        rd(12'h000, 32'hA5);
        chk(outn, 8'h5A);
        chk(act, 8'hA5);
        xfer(1'b1, 12'h00C, 32'h0);
        rd(12'h00C, 32'hFFA5);
        // Linked channels: active where pin matches polarity
        pin <= 8'h3C;
        xfer(1'b1, 12'h008, 32'h0F);
        xfer(1'b1, 12'h004, 32'hFF);
        step(12'hEFF);
        chk(outn, 8'h33);
        rd(12'h00C, 32'h3CCC);
        rd(12'h010, 32'hEFF);
        $display("test channels done");
        // Falls on all gauge pins, lockout pulse, then rises
        step(12'h898);
        chk(g, 8'hE6);
        step(12'h890);
        chk(g, 8'h26);
        step(12'h898);
        chk(g, 8'hE6);
        step(12'hEFF);
        chk(g, 8'h18);
        $display("test gauges done");
        npulse = 0;
        step(12'hE7F);
        chk(npulse, 1);
        step(12'hEFF);
        chk(npulse, 1);
        // Override blocks five pins but not the thermal pair
        step(12'hFFF);
        step(12'h998);
        chk(g, 8'h00);
        step(12'hEFF);
        chk(g, 8'h18);
        $display("test override done");
        chk({kpen, tchen}, 2'b11);
        step(12'hEEF);
        chk({kpen, tchen}, 2'b01);
        step(12'h6FF);
        chk({kpen, tchen}, 2'b00);
        step(12'hEFF);
        rd(12'h018, 32'hFFF);
        xfer(1'b1, 12'h018, 32'hFFF);
        rd(12'h018, 32'h0);
        $display("test lockouts done");
        test_done();
    end
endmodule
`default_nettype wire
